// ### design/qiwr_ctrl.sv
// qiwr_ctrl: spi command front end for dual/quad i/o reads, opcode skip and wrap
// assumes sclk well below CLK/4; memory array is outside, read by byte address
// How it works
// - word read: two dummy clocks after mode
// - word and octal reads need quad enable
// - octal read: data right after mode byte
// - mode byte follows address before dummies
// - mode bits 7:6 and 3:0 ignored
// - field 10 keeps read type, skips opcode
// - other field value leaves continuous mode
// - skip applies to four dual/quad reads
// - wrap command: opcode, 24 dummy, 8 bits
// - only wrap bits 6:4 stored
// - disable bit and length field select wrap
// - quad and word reads wrap within aligned page section
// - wrap setting persists until rewritten
// - power-up wrap disabled
// - in continuous mode first bits are address
// - escape forces release bit to one
// - escape: 8 quad or 16 dual clocks ones
// - quad read: four dummy clocks
// - dual: two bits per clock
`timescale 1ns/100ps
module qiwr_ctrl (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic [3:0]  DATA_IN,
  output logic      [3:0]  DATA_OUT,
  output logic      [3:0]  DATA_OE,
  input  wire logic        QUAD_IO_ENABLE_BIT,
  output logic      [23:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_DATA,
  output logic      [2:0]  WRAP_SETTING_BITS,
  output logic             CONT_MODE
);
  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_SKIP}
    qiwr_state_t;
  // local aliases of the package read kinds; nothing is imported
  typedef qiwr_pkg::qiwr_read_t qiwr_read_t;
  localparam qiwr_read_t RD_NONE  = qiwr_pkg::RD_NONE;
  localparam qiwr_read_t RD_DUAL  = qiwr_pkg::RD_DUAL;
  localparam qiwr_read_t RD_QUAD  = qiwr_pkg::RD_QUAD;
  localparam qiwr_read_t RD_WORD  = qiwr_pkg::RD_WORD;
  localparam qiwr_read_t RD_OCTAL = qiwr_pkg::RD_OCTAL;

  logic [5:0] pin_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] din_s;
  qiwr_sync #(.W(6)) u_sync (
    .clk      (CLK),
    .async_in ({CS_N, SCLK, DATA_IN}),
    .sync_out (pin_s)
  );
  assign cs_n_s = pin_s[5];
  assign sclk_s = pin_s[4];
  assign din_s  = pin_s[3:0];

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] dummy_of(input qiwr_read_t t);
    unique case (t)
      RD_WORD:  dummy_of = qiwr_pkg::DUMMY_WORD;
      RD_OCTAL: dummy_of = qiwr_pkg::DUMMY_OCTAL;
      RD_QUAD:  dummy_of = qiwr_pkg::DUMMY_QUAD;
      default:  dummy_of = 6'h00;
    endcase
  endfunction

  // next byte address, confined to the wrap section when enabled
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [2:0] w,
                                            input logic wrap_ok);
    logic [7:0] mask;
    mask = 8'h07;
    unique case (w[2:1])
      2'h0: mask = 8'h07;
      2'h1: mask = 8'h0F;
      2'h2: mask = 8'h1F;
      2'h3: mask = 8'h3F;
    endcase
    if (w[0] || !wrap_ok) begin
      next_addr = a + 24'h00_0001;
    end else begin
      next_addr = {a[23:8], (a[7:0] & ~mask) | ((a[7:0] + 8'h01) & mask)};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic        sclk_d1_q;
  logic        rise;
  logic        fall;
  logic        quad_bus;
  qiwr_state_t state_q;
  qiwr_read_t  rtype_q;
  qiwr_read_t  skip_type_q;
  logic [5:0]  cnt_q;
  logic [23:0] sh_q;
  logic [7:0]  byte_q;
  logic        nib_q;
  logic        wrap_cmd_q;
  logic        cs_n_d1_q;
  qiwr_read_t  opc_type;

  always_ff @(posedge CLK) begin
    sclk_d1_q <= sclk_s;
    cs_n_d1_q <= cs_n_s;
  end
  assign rise = sclk_s & ~sclk_d1_q;
  assign fall = ~sclk_s & sclk_d1_q;
  assign quad_bus = (rtype_q != RD_DUAL);

  always_comb begin
    opc_type = RD_NONE;
    unique case ({sh_q[6:0], din_s[0]})
      qiwr_pkg::OP_DUAL_IO:   opc_type = RD_DUAL;
      qiwr_pkg::OP_QUAD_IO:   opc_type = QUAD_IO_ENABLE_BIT ? RD_QUAD : RD_NONE;
      qiwr_pkg::OP_WORD_QIO:  opc_type = QUAD_IO_ENABLE_BIT ? RD_WORD : RD_NONE;
      qiwr_pkg::OP_OCTAL_QIO: opc_type = QUAD_IO_ENABLE_BIT ? RD_OCTAL : RD_NONE;
      default:                opc_type = RD_NONE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q     <= S_IDLE;
      rtype_q     <= RD_NONE;
      skip_type_q <= RD_NONE;
      cnt_q       <= 6'h00;
      sh_q        <= 24'h00_0000;
      wrap_cmd_q  <= 1'b0;
      WRAP_SETTING_BITS <= qiwr_pkg::WRAP_RESET;
    end else if (cs_n_s) begin
      state_q <= S_IDLE;
      cnt_q   <= 6'h00;
    end else if (cs_n_d1_q) begin
      // select start: continuous mode takes no opcode, straight into address; otherwise opcode
      wrap_cmd_q <= 1'b0;
      sh_q       <= 24'h00_0000;
      cnt_q      <= 6'h00;
      if (skip_type_q != RD_NONE) begin
        rtype_q <= skip_type_q;
        state_q <= S_ADDR;
      end else begin
        rtype_q <= RD_NONE;
        state_q <= S_OPC;
      end
    end else if (rise) begin
      cnt_q <= cnt_q + 6'h01;
      unique case (state_q)
        S_OPC: begin
          sh_q <= {sh_q[22:0], din_s[0]};
          if (cnt_q == 6'h07) begin
            cnt_q <= 6'h00;
            sh_q  <= 24'h00_0000;
            if (opc_type != RD_NONE) begin
              rtype_q <= opc_type;
              state_q <= S_ADDR;
            end else if ({sh_q[6:0], din_s[0]} == qiwr_pkg::OP_SET_WRAP) begin
              wrap_cmd_q <= 1'b1;
              rtype_q    <= RD_QUAD;
              state_q    <= S_ADDR;
            end else begin
              state_q <= S_SKIP;
            end
          end
        end
        S_ADDR: begin
          if (quad_bus) begin
            sh_q <= {sh_q[19:0], din_s};
          end else begin
            sh_q <= {sh_q[21:0], din_s[1:0]};
          end
          if (cnt_q == (quad_bus ? qiwr_pkg::ADDR_CLK_Q : qiwr_pkg::ADDR_CLK_D) - 6'h01) begin
            cnt_q   <= 6'h00;
            state_q <= S_MODE;
          end
        end
        S_MODE: begin
          if (quad_bus) begin
            byte_q <= {byte_q[3:0], din_s};
          end else begin
            byte_q <= {byte_q[5:0], din_s[1:0]};
          end
          if (cnt_q == (quad_bus ? qiwr_pkg::MODE_CLK_Q : qiwr_pkg::MODE_CLK_D) - 6'h01) begin
            cnt_q <= 6'h00;
            if (wrap_cmd_q) begin
              // only bits 6:4 are kept
              WRAP_SETTING_BITS <= byte_q[2:0];
              state_q <= S_SKIP;
            end else begin
              // only bits 5:4 matter; an escape of all ones lands here with 11
              if ((quad_bus ? byte_q[1:0] : byte_q[3:2]) == qiwr_pkg::SKIP_KEEP) begin
                skip_type_q <= rtype_q;
              end else begin
                skip_type_q <= RD_NONE;
              end
              state_q <= (dummy_of(rtype_q) == 6'h00) ? S_DATA : S_DUMMY;
            end
          end
        end
        S_DUMMY: begin
          if (cnt_q == dummy_of(rtype_q) - 6'h01) begin
            cnt_q   <= 6'h00;
            state_q <= S_DATA;
          end
        end
        S_DATA: cnt_q <= 6'h00;
        S_SKIP: cnt_q <= 6'h00;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data output, changes on sclk falling edge
  logic oe_d;
  assign oe_d = (state_q == S_DATA) && !cs_n_s;
  always_ff @(posedge CLK) begin
    if (SRST || cs_n_s) begin
      DATA_OE  <= 4'h0;
      DATA_OUT <= 4'h0;
      nib_q    <= 1'b0;
      MEM_ADDR <= 24'h00_0000;
    end else if (state_q == S_MODE) begin
      MEM_ADDR <= sh_q;
      nib_q    <= 1'b0;
    end else if (oe_d && fall) begin
      DATA_OE <= quad_bus ? 4'hF : 4'h3;
      if (quad_bus) begin
        DATA_OUT <= nib_q ? MEM_DATA[3:0] : MEM_DATA[7:4];
        nib_q    <= ~nib_q;
        if (nib_q) begin
          MEM_ADDR <= next_addr(MEM_ADDR, WRAP_SETTING_BITS, rtype_q != RD_OCTAL);
        end
      end else begin
        DATA_OUT <= {2'h0, MEM_DATA[7:6]};
        MEM_ADDR <= MEM_ADDR;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      CONT_MODE <= 1'b0;
    end else begin
      CONT_MODE <= (skip_type_q != RD_NONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks on what the sequencer drives
  logic mode_last;
  assign mode_last = (state_q == S_MODE) && rise && !cs_n_s && !cs_n_d1_q &&
    (cnt_q == (quad_bus ? qiwr_pkg::MODE_CLK_Q : qiwr_pkg::MODE_CLK_D) - 6'h01);

  a_oe_deselect: assert property (@(posedge CLK) disable iff (SRST)
    cs_n_s |=> (DATA_OE == 4'h0))
    else $error("data lines driven after deselect");
  a_oe_in_data: assert property (@(posedge CLK) disable iff (SRST)
    (DATA_OE != 4'h0) |-> (state_q == S_DATA))
    else $error("data lines driven outside data phase");
  a_refuse_octal: assert property (@(posedge CLK) disable iff (SRST)
    ((state_q == S_OPC) && rise && !cs_n_s && !cs_n_d1_q && (cnt_q == 6'h07) &&
     !QUAD_IO_ENABLE_BIT && ({sh_q[6:0], din_s[0]} == qiwr_pkg::OP_OCTAL_QIO))
    |=> (state_q == S_SKIP))
    else $error("octal read taken without quad enable");
  a_wrap_store: assert property (@(posedge CLK) disable iff (SRST)
    (mode_last && wrap_cmd_q) |=> (WRAP_SETTING_BITS == $past(byte_q[2:0])))
    else $error("wrap bits not taken from byte bits 6:4");
  a_wrap_hold: assert property (@(posedge CLK) disable iff (SRST)
    !(mode_last && wrap_cmd_q) |=> $stable(WRAP_SETTING_BITS))
    else $error("wrap setting changed without wrap command");
  a_skip_keep: assert property (@(posedge CLK) disable iff (SRST)
    (mode_last && !wrap_cmd_q &&
     ((quad_bus ? byte_q[1:0] : byte_q[3:2]) == qiwr_pkg::SKIP_KEEP))
    |=> (skip_type_q == $past(rtype_q)))
    else $error("opcode skip not kept for field 10");
  a_skip_leave: assert property (@(posedge CLK) disable iff (SRST)
    (mode_last && !wrap_cmd_q &&
     ((quad_bus ? byte_q[1:0] : byte_q[3:2]) != qiwr_pkg::SKIP_KEEP))
    |=> (skip_type_q == RD_NONE))
    else $error("continuous mode kept for other field value");
  a_reentry_addr: assert property (@(posedge CLK) disable iff (SRST)
    (cs_n_d1_q && !cs_n_s && (skip_type_q != RD_NONE)) |=> (state_q == S_ADDR))
    else $error("continuous mode did not start with address");
  a_word_dummy: assert property (@(posedge CLK) disable iff (SRST)
    ((state_q == S_DUMMY) && (rtype_q == RD_WORD)) |-> (cnt_q < qiwr_pkg::DUMMY_WORD))
    else $error("word read dummy count overrun");
  a_octal_direct: assert property (@(posedge CLK) disable iff (SRST)
    (state_q == S_DUMMY) |-> (rtype_q != RD_OCTAL))
    else $error("octal read entered dummy phase");

  c_cont_entered: cover property (@(posedge CLK) disable iff (SRST) $rose(CONT_MODE));
  c_wrap_on:      cover property (@(posedge CLK) disable iff (SRST) !WRAP_SETTING_BITS[0]);
  c_quad_data:    cover property (@(posedge CLK) disable iff (SRST) DATA_OE == 4'hF);
  c_dual_data:    cover property (@(posedge CLK) disable iff (SRST) DATA_OE == 4'h3);
endmodule // qiwr_ctrl

// ### design/qiwr_pkg.sv
// qiwr_pkg: constants for the quad i/o word read and wrap control block
// assumes spi mode 0 framing, sampled on the 20 MHz system clock
package qiwr_pkg;
  localparam logic [7:0] OP_DUAL_IO   = 8'h00BB;
  localparam logic [7:0] OP_QUAD_IO   = 8'h00EB;
  localparam logic [7:0] OP_WORD_QIO  = 8'h00E7;
  localparam logic [7:0] OP_OCTAL_QIO = 8'h00E3;
  localparam logic [7:0] OP_SET_WRAP  = 8'h0077;
  localparam int         ADDR_BITS    = 24;
  localparam int         SKIP_LSB     = 4;
  localparam logic [1:0] SKIP_KEEP    = 2'h2;
  localparam int         WRAP_LSB     = 4;
  localparam logic [2:0] WRAP_RESET   = 3'h1;
  localparam logic [5:0] DUMMY_WORD   = 6'h02;
  localparam logic [5:0] DUMMY_QUAD   = 6'h04;
  localparam logic [5:0] DUMMY_OCTAL  = 6'h00;
  localparam logic [5:0] WRAP_DUMMY   = 6'h06;
  localparam logic [5:0] ADDR_CLK_Q   = 6'h06;
  localparam logic [5:0] ADDR_CLK_D   = 6'h0C;
  localparam logic [5:0] MODE_CLK_Q   = 6'h02;
  localparam logic [5:0] MODE_CLK_D   = 6'h04;
  typedef enum logic [2:0] {RD_NONE, RD_DUAL, RD_QUAD, RD_WORD, RD_OCTAL} qiwr_read_t;
endpackage

// ### design/qiwr_sync.sv
// qiwr_sync: two flip-flop synchroniser for pin inputs
// assumes inputs asynchronous to CLK
`timescale 1ns/100ps
module qiwr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    meta_q   <= async_in;
    sync_out <= meta_q;
  end
endmodule // qiwr_sync

// ### bench/qiwr_host.sv
// qiwr_host: behavioural spi host with four data lines, mode 0 framing
// assumes CLK is the 20 MHz system clock; sclk is CLK/8 (400 ns)
`timescale 1ns/100ps
module qiwr_host (
  input  wire logic       CLK,
  output logic            CS_N,
  output logic            SCLK,
  output logic [3:0]      DATA_IN,
  input  wire logic [3:0] DATA_OUT,
  input  wire logic [3:0] DATA_OE
);
  logic       drv;
  logic [3:0] val;
  logic [3:0] r;
  // released lines show the inverse, so a stale value never passes
  assign DATA_IN = (DATA_OE & DATA_OUT) | (~DATA_OE & (drv ? val : ~val));
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    drv  = 1'b0;
    val  = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic clk1(input logic [3:0] v, output logic [3:0] q);
    val = v;
    repeat (4) @(negedge CLK);
    SCLK = 1'b1;
    q = DATA_IN;
    repeat (4) @(negedge CLK);
    SCLK = 1'b0;
  endtask
  task automatic sel();
    CS_N = 1'b0;
    drv  = 1'b1;
    repeat (4) @(negedge CLK);
  endtask
  task automatic desel();
    repeat (4) @(negedge CLK);
    CS_N = 1'b1;
    drv  = 1'b0;
    repeat (8) @(negedge CLK);
  endtask
  task automatic op(input logic [7:0] o);
    for (int i = 7; i >= 0; i--) clk1({3'h0, o[i]}, r);
  endtask
  task automatic quad(input logic [31:0] w);
    for (int i = 0; i < 8; i++) clk1(w[31-4*i -: 4], r);
  endtask
  task automatic dual(input logic [31:0] w);
    for (int i = 0; i < 16; i++) clk1({2'h0, w[31-2*i -: 2]}, r);
  endtask
  task automatic dummy(input int n);
    drv = 1'b0;
    for (int i = 0; i < n; i++) clk1(val, r);
  endtask
  task automatic rdb(output logic [7:0] b);
    drv = 1'b0;
    clk1(val, r);
    b[7:4] = r;
    clk1(val, r);
    b[3:0] = r;
  endtask
endmodule // qiwr_host

// ### bench/test_quad_io_word_read_wrap_control.sv
// test_quad_io_word_read_wrap_control: directed scenarios for qiwr_ctrl
// assumes qiwr_host as far side and a combinational array model here
`timescale 1ns/100ps
module test_quad_io_word_read_wrap_control;
  logic        CLK, SRST, CS_N, SCLK, QUAD_IO_ENABLE_BIT, CONT_MODE;
  logic [3:0]  DATA_IN, DATA_OUT, DATA_OE;
  logic [23:0] MEM_ADDR;
  logic [7:0]  MEM_DATA, b;
  logic [2:0]  WRAP_SETTING_BITS;
  int          bad_count, cmp_count;
  assign MEM_DATA = MEM_ADDR[7:0] ^ 8'h3C;
  qiwr_ctrl qiwr_ctrl_inst (.CLK(CLK), .SRST(SRST), .CS_N(CS_N), .SCLK(SCLK),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .QUAD_IO_ENABLE_BIT(QUAD_IO_ENABLE_BIT), .MEM_ADDR(MEM_ADDR), .MEM_DATA(MEM_DATA),
    .WRAP_SETTING_BITS(WRAP_SETTING_BITS), .CONT_MODE(CONT_MODE));
  qiwr_host qiwr_host_inst (.CLK(CLK), .CS_N(CS_N), .SCLK(SCLK), .DATA_IN(DATA_IN),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mv(input logic [7:0] a);
    return a ^ 8'h3C;
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_word_cont();
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_WORD_QIO);
    qiwr_host_inst.quad({24'h00_0102, 8'hA5});
    qiwr_host_inst.dummy(2);
    qiwr_host_inst.rdb(b);
    chk("word_b0", mv(8'h02), b);
    qiwr_host_inst.rdb(b);
    chk("word_b1", mv(8'h03), b);
    qiwr_host_inst.desel();
    chk("cont_kept", 1, CONT_MODE);
    chk("oe_idle", 0, DATA_OE);
    // no opcode: the first nibbles are address
    qiwr_host_inst.sel();
    qiwr_host_inst.quad({24'h00_0204, 8'h20});
    qiwr_host_inst.dummy(2);
    qiwr_host_inst.rdb(b);
    chk("skip_b0", mv(8'h04), b);
    qiwr_host_inst.desel();
    qiwr_host_inst.sel();
    qiwr_host_inst.quad(32'hFFFF_FFFF);
    qiwr_host_inst.desel();
    chk("cont_escaped", 0, CONT_MODE);
  endtask
  task automatic t_refuse();
    QUAD_IO_ENABLE_BIT = 1'b0;
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_OCTAL_QIO);
    qiwr_host_inst.quad({24'h00_0010, 8'h20});
    qiwr_host_inst.rdb(b);
    chk("oe_refused", 0, DATA_OE);
    qiwr_host_inst.desel();
    chk("cont_refused", 0, CONT_MODE);
    QUAD_IO_ENABLE_BIT = 1'b1;
  endtask
  task automatic t_wrap_octal();
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_SET_WRAP);
    qiwr_host_inst.quad({24'h00_0000, 8'h8F});
    qiwr_host_inst.desel();
    chk("wrap_bits", 3'h0, WRAP_SETTING_BITS);
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_QUAD_IO);
    qiwr_host_inst.quad({24'h00_0006, 8'h00});
    qiwr_host_inst.dummy(4);
    for (int i = 0; i < 3; i++) begin
      qiwr_host_inst.rdb(b);
      chk("wrap_rd", mv(8'h06 + i & 8'h07), b);
    end
    qiwr_host_inst.desel();
    chk("wrap_kept", 3'h0, WRAP_SETTING_BITS);
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_OCTAL_QIO);
    qiwr_host_inst.quad({24'h00_0010, 8'h20});
    qiwr_host_inst.rdb(b);
    chk("octal_b0", mv(8'h10), b);
    qiwr_host_inst.desel();
    chk("cont_octal", 1, CONT_MODE);
    qiwr_host_inst.sel();
    qiwr_host_inst.quad({24'h00_0020, 8'h00});
    qiwr_host_inst.rdb(b);
    chk("octal_skip_b0", mv(8'h20), b);
    qiwr_host_inst.desel();
    chk("cont_left", 0, CONT_MODE);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_after_reset();
    qiwr_host_inst.sel();
    qiwr_host_inst.quad(32'hFFFF_FFFF);
    qiwr_host_inst.desel();
    chk("cont_reset", 0, CONT_MODE);
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_SET_WRAP);
    qiwr_host_inst.quad({24'h00_0000, 8'h10});
    qiwr_host_inst.desel();
    chk("wrap_off", 3'h1, WRAP_SETTING_BITS);
  endtask
  task automatic t_dual();
    qiwr_host_inst.sel();
    qiwr_host_inst.op(qiwr_pkg::OP_DUAL_IO);
    qiwr_host_inst.dual({24'h00_0040, 8'h20});
    qiwr_host_inst.dummy(1);
    chk("dual_b0", mv(8'h40) >> 6, qiwr_host_inst.r[1:0]);
    qiwr_host_inst.desel();
    chk("cont_dual", 1, CONT_MODE);
    qiwr_host_inst.sel();
    qiwr_host_inst.dual(32'hFFFF_FFFF);
    qiwr_host_inst.desel();
    chk("cont_dual_esc", 0, CONT_MODE);
  endtask
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    report_and_stop();
  end
  initial begin
    SRST = 1'b1;
    QUAD_IO_ENABLE_BIT = 1'b1;
    repeat (6) @(negedge CLK);
    SRST = 1'b0;
    repeat (3) @(negedge CLK);
    chk("wrap_reset", 3'h1, WRAP_SETTING_BITS);
    t_after_reset();
    t_word_cont();
    t_refuse();
    t_wrap_octal();
    t_dual();
    report_and_stop();
  end
endmodule // test_quad_io_word_read_wrap_control
